//--- ubcm_bus_node.sv
// shared-bus partner: pull-up wire plus a second node that can drive it dominant low
`timescale 1ns/1ps
module ubcm_bus_node #(
  parameter int unsigned LAT = 1
) (
  input  wire logic mclk,
  input  wire logic drv_val,
  input  wire logic drv_en,
  input  wire logic dom_req,
  output logic      bus_line
);
  logic [7:0] dly_q = 8'h00;
  logic [8:0] chain;

  // a slow node reaches the wire LAT cycles after it decides to pull low
  always @(posedge mclk) dly_q <= {dly_q[6:0], dom_req};
  assign chain = {dly_q, dom_req};
  // released or undriven wire sits at the pull-up level, never at the last value
  assign bus_line = chain[LAT] ? 1'b0 : (drv_en ? drv_val : 1'b1);
endmodule : ubcm_bus_node

//--- ubcm_core.sv
// serial channel in bus collision mode: registers, baud generator, tx, rx, collision
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module ubcm_core #(
  parameter int unsigned DATA_BITS = 9
) (
  input  wire logic                   mclk,
  input  wire logic                   resetn,
  input  wire ubcm_pkg::ubcm_reg_req_t reg_req,
  output logic [ubcm_pkg::DW-1:0]     reg_rdata,
  input  wire logic                   serial_in_pin,
  input  wire logic                   ext_clock_pin,
  input  wire logic                   sample_timer_underflow,
  output logic                        serial_out_pin_o,
  output logic                        serial_out_pin_oe,
  output logic                        tx_irq,
  output logic                        rx_irq,
  output logic                        collision_irq
);

  if (DATA_BITS != 9) begin : g_chk
    $error("DATA_BITS must be 9");
  end

  logic [7:0] baud_div_q, chan_mode_q, clk_fmt_q, coll_mode_q;
  logic [7:0] spec_b_q, spec_c_q, spec_d_q;
  logic [8:0] tx_buf_q;
  logic       te_q, re_q, irs_q, ti_q, shift_reg_empty_flag_q, ri_q, coll_pend_q;
  ubcm_pkg::ubcm_rx_word_t rx_word_q;
  ubcm_pkg::ubcm_tx_state_t tx_state_q;
  ubcm_pkg::ubcm_rx_state_t rx_state_q;

  wire mode_ok  = chan_mode_q[ubcm_pkg::CM_MODE_LSB +: 3] == ubcm_pkg::MODE_COLL;
  wire par_en   = chan_mode_q[ubcm_pkg::CM_PAR_EN];
  wire stop2    = chan_mode_q[ubcm_pkg::CM_STOP2];
  wire pol_inv  = chan_mode_q[ubcm_pkg::CM_POL_INV];
  wire wr_en    = reg_req.wr;
  wire rd_en    = reg_req.rd;

  // ---- pin synchronisers: stage one feeds stage two only
  logic rx_m_q, rx_s_q, rx_prev_q, ck_m_q, ck_s_q, ck_prev_q;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_m_q    <= 1'b1;
      rx_s_q    <= 1'b1;
      ck_m_q    <= 1'b1;
      ck_s_q    <= 1'b1;
      rx_prev_q <= 1'b1;
      ck_prev_q <= 1'b1;
    end else begin
      rx_m_q    <= serial_in_pin;
      rx_s_q    <= rx_m_q;
      ck_m_q    <= ext_clock_pin;
      ck_s_q    <= ck_m_q;
      rx_prev_q <= rx_s_q ^ pol_inv;
      ck_prev_q <= ck_s_q;
    end
  end
  wire rx_in   = rx_s_q ^ pol_inv;
  wire rx_rise = rx_in & ~rx_prev_q;
  wire rx_fall = ~rx_in & rx_prev_q;

  // ---- count source and baud divider
  logic [5:0] pre_cnt_q, pre_div;
  logic [7:0] brg_cnt_q;
  always_comb begin
    case (clk_fmt_q[ubcm_pkg::CF_PRE_LSB +: 2])
      2'h0:    pre_div = ubcm_pkg::PRE_DIV0;
      2'h1:    pre_div = ubcm_pkg::PRE_DIV1;
      2'h2:    pre_div = ubcm_pkg::PRE_DIV2;
      default: pre_div = ubcm_pkg::PRE_DIV3;
    endcase
  end
  wire pre_tick = pre_cnt_q >= pre_div - 6'h01;
  // external edges are slow compared with mclk; prescaler does not apply to them
  wire src_tick = chan_mode_q[ubcm_pkg::CM_CLK_SRC] ? (ck_s_q & ~ck_prev_q) : pre_tick;
  wire os_tick  = src_tick && brg_cnt_q == 8'h00;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pre_cnt_q <= 6'h00;
      brg_cnt_q <= 8'h00;
    end else begin
      pre_cnt_q <= pre_tick ? 6'h00 : pre_cnt_q + 6'h01;
      if (src_tick) begin
        brg_cnt_q <= (brg_cnt_q == 8'h00) ? baud_div_q : brg_cnt_q - 8'h01;
      end
    end
  end

  // ---- transmitter
  logic [12:0] tx_sh_q;
  logic [3:0]  tx_ph_q, tx_left_q;
  wire tx_en    = te_q & mode_ok;
  wire tx_bit   = os_tick && tx_ph_q == ubcm_pkg::OS_LAST;
  // handshake select is not consulted: flow control stays off in this mode
  wire tx_start = tx_state_q == ubcm_pkg::TX_WAIT && tx_en &&
                  (coll_mode_q[ubcm_pkg::CC_SSS] ? rx_rise : tx_bit);
  wire tx_done  = tx_state_q == ubcm_pkg::TX_SHIFT && tx_bit && tx_left_q == 4'h1;
  wire tx_par   = ^tx_buf_q ^ ~chan_mode_q[ubcm_pkg::CM_PAR_EVEN];
  wire tx_level = (tx_state_q == ubcm_pkg::TX_SHIFT) ? tx_sh_q[0] : 1'b1;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tx_state_q <= ubcm_pkg::TX_IDLE;
      tx_sh_q    <= 13'h1FFF;
      tx_ph_q    <= 4'h0;
      tx_left_q  <= 4'h0;
    end else begin
      if (os_tick) begin
        tx_ph_q <= tx_ph_q + 4'h1;
      end
      case (tx_state_q)
        ubcm_pkg::TX_IDLE: begin
          if (tx_en && !ti_q) begin
            tx_state_q <= ubcm_pkg::TX_WAIT;
            tx_ph_q    <= 4'h0;
          end
        end
        ubcm_pkg::TX_WAIT: begin
          if (!tx_en) begin
            tx_state_q <= ubcm_pkg::TX_IDLE;
          end else if (tx_start) begin
            tx_state_q <= ubcm_pkg::TX_SHIFT;
            tx_ph_q    <= 4'h0;
            // one frame per bus bit: start, nine data, optional parity, stops
            tx_sh_q    <= {2'b11, par_en ? tx_par : 1'b1, tx_buf_q, 1'b0};
            // the stop bits are counted so completion follows the last stop bit
            tx_left_q  <= ubcm_pkg::BITS_BASE + 4'h1 + {3'h0, par_en} + {3'h0, stop2};
          end
        end
        ubcm_pkg::TX_SHIFT: begin
          // dropping transmit enable (by software or collision auto-clear) aborts the frame; the output goes to the idle level next cycle, released only in open drain
          if (!tx_en || tx_done) begin
            tx_state_q <= ubcm_pkg::TX_IDLE;
          end else if (tx_bit) begin
            tx_sh_q   <= {1'b1, tx_sh_q[12:1]};
            tx_left_q <= tx_left_q - 4'h1;
          end
        end
        default: tx_state_q <= ubcm_pkg::TX_IDLE;
      endcase
    end
  end

  wire pin_level = tx_level ^ pol_inv;
  always_comb begin
    if (clk_fmt_q[ubcm_pkg::CF_OPEN_DRAIN]) begin
      serial_out_pin_o  = 1'b0;
      serial_out_pin_oe = ~pin_level;
    end else begin
      serial_out_pin_o  = pin_level;
      serial_out_pin_oe = 1'b1;
    end
  end

  // ---- collision detection
  wire coll_sample = coll_mode_q[ubcm_pkg::CC_COLLISION_SAMPLE_SELECT] ? sample_timer_underflow
                     : (os_tick && tx_ph_q == ubcm_pkg::OS_MID);
  wire coll_event  = tx_state_q == ubcm_pkg::TX_SHIFT && coll_sample && (tx_level != rx_in);
  wire coll_clr    = wr_en && reg_req.addr == ubcm_pkg::OFS_COLL_IRQ &&
                     !reg_req.wdata[ubcm_pkg::CI_PEND];
  wire auto_clr    = coll_event && !coll_pend_q && coll_mode_q[ubcm_pkg::CC_AUTO_TX_DISABLE_ON_COLLISION];
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      coll_pend_q <= 1'b0;
    end else if (coll_event) begin
      coll_pend_q <= 1'b1;
    end else if (coll_clr) begin
      coll_pend_q <= 1'b0;
    end
  end
  assign collision_irq = coll_pend_q;

  // ---- receiver
  logic [11:0] rx_bits_q;
  logic [3:0]  rx_ph_q, rx_idx_q;
  wire rx_smp  = rx_state_q == ubcm_pkg::RX_SHIFT && os_tick && rx_ph_q == ubcm_pkg::OS_MID;
  wire [3:0] rx_last = ubcm_pkg::BITS_BASE + {3'h0, par_en};
  wire rx_done = rx_smp && rx_idx_q == rx_last;
  wire [8:0] rx_data = rx_bits_q[9:1];
  wire rx_par_bad = par_en && (rx_bits_q[10] != (^rx_data ^ ~chan_mode_q[ubcm_pkg::CM_PAR_EVEN]));
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_state_q <= ubcm_pkg::RX_IDLE;
      rx_bits_q  <= 12'h000;
      rx_ph_q    <= 4'h0;
      rx_idx_q   <= 4'h0;
    end else begin
      if (os_tick) begin
        rx_ph_q <= rx_ph_q + 4'h1;
      end
      case (rx_state_q)
        ubcm_pkg::RX_IDLE: begin
          if (re_q && mode_ok && rx_fall) begin
            rx_state_q <= ubcm_pkg::RX_SHIFT;
            rx_ph_q    <= 4'h0;
            rx_idx_q   <= 4'h0;
          end
        end
        ubcm_pkg::RX_SHIFT: begin
          if (!re_q || rx_done || (rx_smp && rx_idx_q == 4'h0 && rx_in)) begin
            rx_state_q <= ubcm_pkg::RX_IDLE;
          end
          if (rx_smp) begin
            rx_bits_q[rx_idx_q] <= rx_in;
            rx_idx_q            <= rx_idx_q + 4'h1;
          end
        end
        default: rx_state_q <= ubcm_pkg::RX_IDLE;
      endcase
    end
  end

  // rx_done evaluates with the stop bit arriving now, not yet stored
  wire rx_fer = ~rx_in;
  wire rx_ovr = ri_q;
  wire rd_rxb = rd_en && reg_req.addr == ubcm_pkg::OFS_RX_BUFFER;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_word_q <= '0;
      ri_q      <= 1'b0;
    end else begin
      if (rx_done) begin
        // on overrun the old data stays; the new frame's data is dropped, but its framing and parity flags are stored
        if (!rx_ovr) begin
          rx_word_q.data <= rx_data;
        end
        rx_word_q.overrun <= rx_ovr | rx_word_q.overrun;
        rx_word_q.framing <= rx_fer;
        rx_word_q.parity  <= rx_par_bad;
        rx_word_q.err_sum <= rx_ovr | rx_word_q.overrun | rx_fer | rx_par_bad;
        ri_q              <= 1'b1;
      end else begin
        if (rd_rxb) begin
          ri_q <= 1'b0;
        end
        if (!re_q) begin
          rx_word_q.overrun <= 1'b0;
          rx_word_q.err_sum <= rx_word_q.framing | rx_word_q.parity;
        end
      end
    end
  end
  assign rx_irq = rx_done && !rx_ovr;

  // ---- transmit flags and interrupt cause
  wire wr_txb = wr_en && reg_req.addr == ubcm_pkg::OFS_TX_BUFFER;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ti_q     <= 1'b1;
      shift_reg_empty_flag_q  <= 1'b1;
      tx_buf_q <= 9'h000;
    end else begin
      // a write in the start cycle is fresh data, so the buffer reads full again
      if (wr_txb) begin
        tx_buf_q <= reg_req.wdata[8:0];
        ti_q     <= 1'b0;
      end else if (tx_start) begin
        ti_q <= 1'b1;
      end
      if (tx_start) begin
        shift_reg_empty_flag_q <= 1'b0;
      end else if (tx_done || tx_state_q != ubcm_pkg::TX_SHIFT) begin
        shift_reg_empty_flag_q <= 1'b1;
      end
    end
  end
  assign tx_irq = irs_q ? tx_done : tx_start;

  // ---- register writes
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      baud_div_q  <= ubcm_pkg::REG8_RST;
      chan_mode_q <= ubcm_pkg::REG8_RST;
      clk_fmt_q   <= ubcm_pkg::REG8_RST;
      coll_mode_q <= ubcm_pkg::REG8_RST;
      spec_b_q    <= ubcm_pkg::REG8_RST;
      spec_c_q    <= ubcm_pkg::REG8_RST;
      spec_d_q    <= ubcm_pkg::REG8_RST;
      te_q        <= 1'b0;
      re_q        <= 1'b0;
      irs_q       <= 1'b0;
    end else begin
      if (wr_en) begin
        case (reg_req.addr)
          ubcm_pkg::OFS_BAUD_DIV:  baud_div_q  <= reg_req.wdata[7:0];
          ubcm_pkg::OFS_CHAN_MODE: chan_mode_q <= reg_req.wdata[7:0];
          ubcm_pkg::OFS_CLK_FMT:   clk_fmt_q   <= reg_req.wdata[7:0];
          ubcm_pkg::OFS_COLL_MODE: coll_mode_q <= reg_req.wdata[7:0];
          ubcm_pkg::OFS_SPEC_B:    spec_b_q    <= reg_req.wdata[7:0];
          ubcm_pkg::OFS_SPEC_C:    spec_c_q    <= reg_req.wdata[7:0];
          ubcm_pkg::OFS_SPEC_D:    spec_d_q    <= reg_req.wdata[7:0];
          ubcm_pkg::OFS_XFER_CTL: begin
            te_q  <= reg_req.wdata[ubcm_pkg::TC_TE];
            re_q  <= reg_req.wdata[ubcm_pkg::TC_RE];
            irs_q <= reg_req.wdata[ubcm_pkg::TC_IRS];
          end
          default: ;
        endcase
      end
      // hardware clear beats a same-cycle software write of the enable
      if (auto_clr) begin
        te_q <= 1'b0;
      end
    end
  end

  // ---- register reads, data one cycle after the strobe
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    case (reg_req.addr)
      ubcm_pkg::OFS_RX_BUFFER: rd_mux = rx_word_q;
      ubcm_pkg::OFS_CHAN_MODE: rd_mux = {8'h00, chan_mode_q};
      ubcm_pkg::OFS_CLK_FMT:   rd_mux = {8'h00, clk_fmt_q[7:4], shift_reg_empty_flag_q, clk_fmt_q[2:0]};
      ubcm_pkg::OFS_XFER_CTL:  rd_mux = {11'h000, irs_q, ri_q, re_q, ti_q, te_q};
      ubcm_pkg::OFS_COLL_MODE: rd_mux = {8'h00, coll_mode_q};
      ubcm_pkg::OFS_SPEC_B:    rd_mux = {8'h00, spec_b_q};
      ubcm_pkg::OFS_SPEC_C:    rd_mux = {8'h00, spec_c_q};
      ubcm_pkg::OFS_SPEC_D:    rd_mux = {8'h00, spec_d_q};
      ubcm_pkg::OFS_COLL_IRQ:  rd_mux = {12'h000, coll_pend_q, 3'h0};
      default:                 rd_mux = 16'h0000;
    endcase
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (rd_en) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ---- checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_coll;
    coll_event && !coll_pend_q && coll_mode_q[ubcm_pkg::CC_AUTO_TX_DISABLE_ON_COLLISION];
  endsequence
  sequence s_te_gone;
    !te_q && coll_pend_q;
  endsequence

  AST_COLL_SETS: assert property (coll_event |=> coll_pend_q)
    else $error("collision did not set the pending flag");
  AST_AUTO_CLEAR: assert property (s_coll |=> s_te_gone)
    else $error("transmit enable not cleared on collision");
  AST_START_LEVEL: assert property (tx_start |=> tx_state_q == ubcm_pkg::TX_SHIFT
                                   && !tx_level && (ti_q || $past(wr_txb)))
    else $error("frame did not open with a start bit");
  AST_TX_NEEDS_TE: assert property (tx_start |-> te_q && mode_ok && !ti_q)
    else $error("transmission began without enable");
  AST_SSS_EDGE: assert property (tx_start && coll_mode_q[ubcm_pkg::CC_SSS]
                                |-> rx_in && !rx_prev_q)
    else $error("edge start without rising input");
  AST_PAR_OFF: assert property (rx_done && !par_en |=> !rx_word_q.parity)
    else $error("parity flagged while parity disabled");
  AST_OPEN_DRAIN: assert property (clk_fmt_q[ubcm_pkg::CF_OPEN_DRAIN] && pin_level
                                  |-> !serial_out_pin_oe)
    else $error("open drain output drove a high level");
  AST_RX_READ: assert property (rd_rxb |=> reg_rdata[8:0] == $past(rx_word_q.data))
    else $error("rx data not returned one cycle after read");
  AST_TX_IRQ: assert property (irs_q && tx_done |-> tx_irq ##1 shift_reg_empty_flag_q)
    else $error("completion cause did not interrupt");

endmodule : ubcm_core

//--- ubcm_core_test.sv
// self-checking bench of the bus collision serial channel on a shared wire
`timescale 1ns/1ps
module ubcm_core_test;
  typedef struct packed {
    logic [3:0]  a;
    logic [15:0] d;
    logic [15:0] e;
  } ubcm_row_t;
  logic mclk, resetn, ext_clk, tmr_uf, dom_req, stp;
  logic out_o, out_oe, bus_line, tx_irq, rx_irq, coll_irq;
  logic [15:0] rdata, got, dv;
  logic [8:0] fd;
  ubcm_pkg::ubcm_reg_req_t req;
  int errors, cmp_count, n_tx, n_rx, k;
  // address, write value, value read back
  ubcm_row_t rows [9] = '{
    '{4'h3, 16'hFFCE, 16'h00CE}, '{4'h4, 16'h00F7, 16'h00FF},
    '{4'h6, 16'h0070, 16'h0070}, '{4'h7, 16'hFF5A, 16'h005A},
    '{4'h8, 16'h00A5, 16'h00A5}, '{4'h9, 16'h003C, 16'h003C},
    '{4'hB, 16'hFFFF, 16'h0000}, '{4'h1, 16'h01FF, 16'h0000},
    '{4'h5, 16'h00E0, 16'h0002}};
  // a = {expected request, timer pulse}, d = collision mode, e = transmit enable after
  ubcm_row_t coll [4] = '{
    '{4'h2, 16'h0020, 16'h0000}, '{4'h2, 16'h0000, 16'h0001},
    '{4'h3, 16'h0010, 16'h0001}, '{4'h0, 16'h0010, 16'h0001}};
  // a = baud divider, d = channel mode, e = clock format; both give 64 clocks a bit
  ubcm_row_t rate [2] = '{'{4'h1, 16'h0006, 16'h0011}, '{4'h0, 16'h000E, 16'h0010}};

  ubcm_core u_ubcm_core (
    .mclk                  (mclk),
    .resetn                (resetn),
    .reg_req               (req),
    .reg_rdata             (rdata),
    .serial_in_pin         (bus_line),
    .ext_clock_pin         (ext_clk),
    .sample_timer_underflow(tmr_uf),
    .serial_out_pin_o      (out_o),
    .serial_out_pin_oe     (out_oe),
    .tx_irq                (tx_irq),
    .rx_irq                (rx_irq),
    .collision_irq         (coll_irq)
  );
  ubcm_bus_node #(.LAT(1)) u_ubcm_bus_node (
    .mclk    (mclk),
    .drv_val (out_o),
    .drv_en  (out_oe),
    .dom_req (dom_req),
    .bus_line(bus_line)
  );

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // external count source, period four system clocks, unrelated phase
  initial begin
    ext_clk = 1'b0;
    #13;
    forever #100 ext_clk = ~ext_clk;
  end
  always @(posedge mclk) begin
    if (tx_irq === 1'b1) n_tx++;
    if (rx_irq === 1'b1) n_rx++;
  end

  task automatic stop_test;
    if (errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask : rd
  task automatic rc(input logic [3:0] a, input logic [15:0] e);
    rd(a, got);
    chk(got, e);
  endtask : rc
  // sel 0 watches the wire, sel 1 the output enable; bounded wait
  task automatic wait_for(input logic sel, input logic v, output int n);
    n = 0;
    while ((sel ? out_oe : bus_line) !== v && n < 2000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 2000) begin
      errors++;
      stop_test();
    end
  endtask : wait_for
  // samples one frame in mid-bit at 16 clocks a bit
  task automatic get_frame(output int n, output logic [8:0] d, output logic s);
    wait_for(1'b0, 1'b0, n);
    repeat (8) @(posedge mclk);
    #1;
    chk({15'h0000, bus_line}, 16'h0000);
    for (int i = 0; i < 9; i++) begin
      repeat (16) @(posedge mclk);
      #1;
      d[i] = bus_line;
    end
    repeat (16) @(posedge mclk);
    #1;
    s = bus_line;
  endtask : get_frame

  initial begin
    resetn = 1'b0;
    req = '0;
    tmr_uf = 1'b0;
    dom_req = 1'b0;
    errors = 0;
    cmp_count = 0;
    n_tx = 0;
    n_rx = 0;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    @(negedge mclk);
    chk({13'h0000, out_o, out_oe, coll_irq}, 16'h0006);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rc(rows[i].a, rows[i].e);
    end
    foreach (rows[i]) wr(rows[i].a, 16'h0000);
    wr(4'h4, 16'h0010);
    for (int c = 0; c < 2; c++) begin
      dv = c ? 16'h005A : 16'h01A5;
      wr(4'h3, c ? 16'h0026 : 16'h0006);
      wr(4'h5, c ? 16'h0015 : 16'h0005);
      n_tx = 0;
      n_rx = 0;
      wr(4'h0, dv);
      get_frame(k, fd, stp);
      chk(16'(n_tx), c ? 16'h0000 : 16'h0001);
      chk(16'(k < 20), 16'h0001);
      chk({7'h00, fd}, dv);
      chk({15'h0000, stp}, 16'h0001);
      repeat (24) @(posedge mclk);
      chk(16'(n_tx * 2 + n_rx), 16'h0003);
      rc(4'h1, dv);
      rc(4'h4, 16'h0018);
      chk({15'h0000, coll_irq}, 16'h0000);
    end
    foreach (rate[i]) begin
      wr(4'h2, {12'h000, rate[i].a});
      wr(4'h4, rate[i].e);
      wr(4'h3, rate[i].d);
      wr(4'h0, 16'h0001);
      wait_for(1'b0, 1'b0, k);
      wait_for(1'b0, 1'b1, k);
      chk(16'(k), 16'h0040);
      repeat (700) @(posedge mclk);
    end
    // second frame arrived unread: old data kept, overrun and error sum raised
    rc(4'h1, 16'h9001);
    wr(4'h2, 16'h0000);
    wr(4'h4, 16'h0010);
    wr(4'h3, 16'h0006);
    foreach (coll[i]) begin
      wr(4'h6, coll[i].d);
      wr(4'h5, 16'h0005);
      wr(4'h0, 16'h01FF);
      wait_for(1'b0, 1'b0, k);
      // the other node pulls the wire low across the second data bit
      repeat (31) @(posedge mclk);
      dom_req <= 1'b1;
      repeat (8) @(posedge mclk);
      tmr_uf <= coll[i].a[0];
      @(posedge mclk);
      tmr_uf <= 1'b0;
      repeat (7) @(posedge mclk);
      dom_req <= 1'b0;
      repeat (4) @(posedge mclk);
      chk({15'h0000, coll_irq}, {15'h0000, coll[i].a[1]});
      rc(4'hA, {12'h000, coll[i].a[1], 3'b000});
      rd(4'h5, got);
      chk(got & 16'h0001, coll[i].e);
      repeat (180) @(posedge mclk);
      wr(4'h5, 16'h0000);
      wr(4'hA, 16'h0000);
      rc(4'hA, 16'h0000);
    end
    wr(4'h4, 16'h0030);
    wr(4'h6, 16'h0040);
    dom_req <= 1'b1;
    wr(4'h5, 16'h0005);
    wr(4'h0, 16'h0155);
    k = 0;
    repeat (40) begin
      @(posedge mclk);
      #1;
      if (out_oe !== 1'b0) k++;
    end
    chk(16'(k), 16'h0000);
    @(posedge mclk);
    dom_req <= 1'b0;
    wait_for(1'b1, 1'b1, k);
    chk(16'(k < 8), 16'h0001);
    chk({14'h0000, out_o, out_oe}, 16'h0001);
    repeat (200) @(posedge mclk);
    stop_test();
  end

  // the whole sequence needs about 3500 clocks
  initial begin
    #(20000 * 50);
    errors++;
    stop_test();
  end
endmodule : ubcm_core_test

//--- ubcm_pkg.sv
// constants, field layout and carrier types of the bus collision serial channel
//
// Overview of operation
// - each shared-bus bit is sent as one whole asynchronous character frame
// - driven output level differing from sampled input raises the collision request
// - transmit and receive buffers carry nine data bits per frame
// - parity generation and check off while parity enable is zero
// - handshake select ignored; handshake disable keeps flow control off
// - clock source select picks internal prescaled clock or external clock
// - two-bit prescaler select feeds the 8-bit baud divider setting bit rate
// - line polarity bit inverts serial output and serial input levels
// - output drive type selects push-pull or open-drain serial output
// - transmit only with transmit enable, receive only with receive enable
// - transmit buffer empty and shift register empty flags readable
// - transmit interrupt cause select picks buffer-empty or transfer-done event
// - collision sample select moves the comparison to sampling timer underflow
// - auto-clear clears transmit enable as the collision flag becomes one
// - start select zero: sending starts one transfer clock after enable
// - start select one: sending starts on rising edge of serial input
package ubcm_pkg;

  localparam int unsigned AW = 4;
  localparam int unsigned DW = 16;

  // register indices on the plain register port
  localparam logic [3:0] OFS_TX_BUFFER  = 4'h0;
  localparam logic [3:0] OFS_RX_BUFFER  = 4'h1;
  localparam logic [3:0] OFS_BAUD_DIV   = 4'h2;
  localparam logic [3:0] OFS_CHAN_MODE  = 4'h3;
  localparam logic [3:0] OFS_CLK_FMT    = 4'h4;
  localparam logic [3:0] OFS_XFER_CTL   = 4'h5;
  localparam logic [3:0] OFS_COLL_MODE  = 4'h6;
  localparam logic [3:0] OFS_SPEC_B     = 4'h7;
  localparam logic [3:0] OFS_SPEC_C     = 4'h8;
  localparam logic [3:0] OFS_SPEC_D     = 4'h9;
  localparam logic [3:0] OFS_COLL_IRQ   = 4'hA;

  // channel_mode fields
  localparam int unsigned CM_MODE_LSB   = 0;
  localparam int unsigned CM_CLK_SRC    = 3;
  localparam int unsigned CM_STOP2      = 4;
  localparam int unsigned CM_PAR_EVEN   = 5;
  localparam int unsigned CM_PAR_EN     = 6;
  localparam int unsigned CM_POL_INV    = 7;
  // clock_format_control fields
  localparam int unsigned CF_PRE_LSB    = 0;
  localparam int unsigned CF_HS_SEL     = 2;
  localparam int unsigned CF_SHIFT_REG_EMPTY_FLAG      = 3;
  localparam int unsigned CF_HS_DIS     = 4;
  localparam int unsigned CF_OPEN_DRAIN = 5;
  // transfer_control fields
  localparam int unsigned TC_TE         = 0;
  localparam int unsigned TC_TI         = 1;
  localparam int unsigned TC_RE         = 2;
  localparam int unsigned TC_RI         = 3;
  localparam int unsigned TC_IRS        = 4;
  // collision_mode_control fields
  localparam int unsigned CC_COLLISION_SAMPLE_SELECT      = 4;
  localparam int unsigned CC_AUTO_TX_DISABLE_ON_COLLISION       = 5;
  localparam int unsigned CC_SSS        = 6;
  // collision_irq_control_reg pending bit
  localparam int unsigned CI_PEND       = 3;

  localparam logic [7:0] REG8_RST       = 8'h00;
  localparam logic [2:0] MODE_COLL      = 3'h6;
  localparam int unsigned OS_PER        = 16;
  localparam logic [3:0] OS_LAST        = 4'hF;
  localparam logic [3:0] OS_MID         = 4'h8;
  localparam logic [3:0] BITS_BASE      = 4'hA;
  // prescaler divide ratios for select 0..3
  localparam logic [5:0] PRE_DIV0       = 6'h01;
  localparam logic [5:0] PRE_DIV1       = 6'h02;
  localparam logic [5:0] PRE_DIV2       = 6'h08;
  localparam logic [5:0] PRE_DIV3       = 6'h20;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_WAIT  = 2'b01,
    TX_SHIFT = 2'b10
  } ubcm_tx_state_t;

  typedef enum logic {
    RX_IDLE  = 1'b0,
    RX_SHIFT = 1'b1
  } ubcm_rx_state_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } ubcm_reg_req_t;

  typedef struct packed {
    logic       err_sum;
    logic       parity;
    logic       framing;
    logic       overrun;
    logic [2:0] rsv;
    logic [8:0] data;
  } ubcm_rx_word_t;

endpackage : ubcm_pkg
